// ==== hw/ppo_cfg.svh ====
// offsets, field positions, reset values and responses of the port block
`ifndef PPO_CFG_SVH
`define PPO_CFG_SVH
`define PPO_OFF_DIR     8'h00
`define PPO_OFF_OUT     8'h04
`define PPO_OFF_IN      8'h08
`define PPO_OFF_CTRL    8'h0c
`define PPO_OFF_FLAG    8'h10
`define PPO_CTRL_PUD    0
`define PPO_CTRL_AS2    1
`define PPO_RST_BYTE    8'h00
`define PPO_RESP_OK     2'b00
`define PPO_RESP_ERR    2'b10
`endif

// ==== hw/ppo_pkg.sv ====
// types shared by the port block
package ppo_pkg;
  typedef enum logic [1:0] {
    PPO_ACTIVE = 2'b00,
    PPO_IDLE   = 2'b01,
    PPO_DEEP   = 2'b10
  } ppo_sleep_t;

  typedef struct packed {
    logic en;
    logic master;
    logic sck_out;
    logic slave_out;
    logic master_out;
  } ppo_spi_t;

  typedef struct packed {
    logic t2_en;
    logic t2_out;
    logic t1b_en;
    logic t1b_out;
    logic t1a_en;
    logic t1a_out;
  } ppo_tmr_t;

  typedef struct packed {
    logic crystal;
    logic intrc;
  } ppo_clksrc_t;
endpackage

// ==== hw/ppo_pin_sync.sv ====
// pin input synchronizer: falling-edge hold stage then rising-edge stage
module ppo_pin_sync (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] d,
  output logic      [7:0] q
);
  logic [7:0] hold;

  // the hold stage stands in for a latch open while clk is high
  always_ff @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold <= 8'h00;
    end else begin
      hold <= d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= 8'h00;
    end else begin
      q <= hold;
    end
  end
endmodule

// ==== hw/ppo_port.sv ====
// port b pin logic with alternate-function overrides and register slave
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`include "ppo_cfg.svh"

module ppo_port import ppo_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  pad_in,
  output logic [7:0]       pad_out,
  output logic [7:0]       pad_oe,
  output logic [7:0]       pullup_en,
  output logic [7:0]       alt_digital_in,
  input  wire ppo_sleep_t  sleep_state,
  input  wire logic [7:0]  ext_int_en,
  input  wire logic [7:0]  ext_int_edge,
  output logic [7:0]       ext_int_flag,
  input  wire ppo_spi_t    spi,
  input  wire ppo_tmr_t    tmr,
  input  wire ppo_clksrc_t clk_src
);
  logic [7:0]  pin_direction_bit, next_pin_direction_bit;
  logic [7:0]  pin_output_bit, next_pin_output_bit;
  logic        global_pullup_disable, next_global_pullup_disable;
  logic        async_timer_clk_sel, next_async_timer_clk_sel;
  logic [7:0]  next_ext_int_flag;
  logic        deep_q;
  logic        aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0]  awaddr_q, next_awaddr_q, wdata_q, next_wdata_q;
  logic        wstrb_q, next_wstrb_q;
  logic        next_awready, next_wready, next_bvalid, next_arready;
  logic        next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [7:0]  next_pad_out, next_pad_oe, next_pullup_en;
  logic [7:0]  pin_input_bit;
  logic [7:0]  pullup_override_en, pullup_override_val;
  logic [7:0]  drive_override_en, drive_override_val;
  logic [7:0]  value_override_en, value_override_val;
  logic [7:0]  input_en_override_en, input_en_override_val;
  logic [7:0]  pu_sel, drv_sel, val_sel, die_sel, sleep_ie, clk_pins;
  logic [7:0]  wake_set;
  logic        clk7, clk6, spi_m, deep;
  logic        aw_fire, w_fire, ar_fire, do_wr;

  function automatic logic [7:0] ovr(input logic [7:0] oe,
                                     input logic [7:0] ov,
                                     input logic [7:0] dflt);
    ovr = (oe & ov) | (~oe & dflt);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `PPO_OFF_DIR) || (a == `PPO_OFF_OUT) ||
             (a == `PPO_OFF_IN) || (a == `PPO_OFF_CTRL) ||
             (a == `PPO_OFF_FLAG);
  endfunction

  // oscillator pins take over bits 7 and 6
  assign clk7 = clk_src.crystal |
                (clk_src.intrc & async_timer_clk_sel);
  assign clk6 = ~clk_src.intrc | async_timer_clk_sel;
  assign clk_pins = {clk7, clk6, 6'h00};
  assign spi_m = spi.en & spi.master;
  assign deep = (sleep_state == PPO_DEEP);

  // each pin has its own override lines; spi_m (bits 5 to 2), the clock source (bits 7 and 6), pud and sleep are shared
  assign pullup_override_en = {clk7, clk6, {4{spi_m}}, 2'b00};
  assign pullup_override_val = {2'b00, pin_output_bit[5:2] &
                                {4{global_pullup_disable}}, 2'b00};
  assign drive_override_en = {clk7, clk6, {4{spi_m}}, 2'b00};
  assign drive_override_val = 8'h00;
  assign value_override_en = {2'b00, spi_m, spi_m, spi_m | tmr.t2_en,
                              tmr.t1b_en, tmr.t1a_en, 1'b0};
  assign value_override_val = {2'b00, spi.sck_out, spi.slave_out,
                               spi.master_out | tmr.t2_out,
                               tmr.t1b_out, tmr.t1a_out, 1'b0};
  assign input_en_override_en = {clk7, clk6, 6'h00};
  assign input_en_override_val = 8'h00;

  assign pu_sel = ovr(pullup_override_en, pullup_override_val,
                      ~pin_direction_bit & pin_output_bit &
                      {8{~global_pullup_disable}});
  assign drv_sel = ovr(drive_override_en, drive_override_val,
                       pin_direction_bit);
  assign val_sel = ovr(value_override_en, value_override_val,
                       pin_output_bit);
  // clamp only in deep sleep, and never on an armed interrupt pin
  assign sleep_ie = ~({8{deep}} & ~ext_int_en);
  assign die_sel = ovr(input_en_override_en, input_en_override_val,
                       sleep_ie);
  // unsynchronized: receivers bring their own synchronizer
  assign alt_digital_in = pad_in & die_sel;

  ppo_pin_sync u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (alt_digital_in),
    .q     (pin_input_bit)
  );

  // the clamp makes a pin that is high on wake look like an edge on wake
  assign wake_set = {8{deep_q & ~deep}} & ext_int_edge & ~ext_int_en &
                    pad_in;

  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign do_wr = aw_got & w_got & ~s_axi_bvalid;

  always_comb begin
    next_aw_got = aw_got | aw_fire;
    next_w_got = w_got | w_fire;
    next_awaddr_q = aw_fire ? s_axi_awaddr : awaddr_q;
    next_wdata_q = w_fire ? s_axi_wdata[7:0] : wdata_q;
    next_wstrb_q = w_fire ? s_axi_wstrb[0] : wstrb_q;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    next_pin_direction_bit = pin_direction_bit;
    next_pin_output_bit = pin_output_bit;
    next_global_pullup_disable = global_pullup_disable;
    next_async_timer_clk_sel = async_timer_clk_sel;
    next_ext_int_flag = ext_int_flag | wake_set;
    if (do_wr) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(awaddr_q) ? `PPO_RESP_OK : `PPO_RESP_ERR;
      if (wstrb_q) begin
        case (awaddr_q)
          `PPO_OFF_DIR: begin
            next_pin_direction_bit = wdata_q;
          end
          `PPO_OFF_OUT: begin
            next_pin_output_bit = wdata_q;
          end
          `PPO_OFF_CTRL: begin
            next_global_pullup_disable = wdata_q[`PPO_CTRL_PUD];
            next_async_timer_clk_sel = wdata_q[`PPO_CTRL_AS2];
          end
          `PPO_OFF_FLAG: begin
            // write one clears; a wake edge in the same cycle still wins
            next_ext_int_flag = (ext_int_flag & ~wdata_q) | wake_set;
          end
          default: begin
          end
        endcase
      end
    end
    next_awready = ~next_aw_got;
    next_wready = ~next_w_got;
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (ar_fire) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr) ? `PPO_RESP_OK : `PPO_RESP_ERR;
      case (s_axi_araddr)
        `PPO_OFF_DIR: begin
          next_rdata = {24'h000000, pin_direction_bit & ~clk_pins};
        end
        `PPO_OFF_OUT: begin
          next_rdata = {24'h000000, pin_output_bit & ~clk_pins};
        end
        `PPO_OFF_IN: begin
          next_rdata = {24'h000000, pin_input_bit & ~clk_pins};
        end
        `PPO_OFF_CTRL: begin
          next_rdata = {30'h0, async_timer_clk_sel,
                        global_pullup_disable};
        end
        `PPO_OFF_FLAG: begin
          next_rdata = {24'h000000, ext_int_flag};
        end
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
    next_arready = ~next_rvalid;
    next_pad_oe = drv_sel;
    next_pad_out = drv_sel & val_sel;
    next_pullup_en = pu_sel;
  end

  // async reset drops drivers and pull-ups with no clock needed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_oe <= 8'h00;
      pad_out <= 8'h00;
      pullup_en <= 8'h00;
      pin_direction_bit <= `PPO_RST_BYTE;
      pin_output_bit <= `PPO_RST_BYTE;
      global_pullup_disable <= 1'b0;
      async_timer_clk_sel <= 1'b0;
      ext_int_flag <= 8'h00;
      deep_q <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      pad_oe <= next_pad_oe;
      pad_out <= next_pad_out;
      pullup_en <= next_pullup_en;
      pin_direction_bit <= next_pin_direction_bit;
      pin_output_bit <= next_pin_output_bit;
      global_pullup_disable <= next_global_pullup_disable;
      async_timer_clk_sel <= next_async_timer_clk_sel;
      ext_int_flag <= next_ext_int_flag;
      deep_q <= deep;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_reset_quiet;
    $rose(rst_b) |-> (pad_oe == 8'h00) && (pullup_en == 8'h00);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("pins not quiet after reset");

  property p_drive_en;
    1 |=> pad_oe == $past((drive_override_en & drive_override_val) |
                          (~drive_override_en & pin_direction_bit));
  endproperty
  a_drive_en: assert property (p_drive_en)
    else $error("driver enable wrong");

  property p_pullup;
    !pullup_override_en[0] && !pin_direction_bit[0] &&
      pin_output_bit[0] && !global_pullup_disable |=> pullup_en[0];
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up not enabled in input-high state");

  property p_value;
    value_override_en[1] && drv_sel[1] |=>
      pad_out[1] == $past(tmr.t1a_out);
  endproperty
  a_value: assert property (p_value)
    else $error("override value not driven");

  property p_clamp;
    deep |-> (alt_digital_in & ~ext_int_en & ~input_en_override_en) == 8'h00;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("input not clamped in deep sleep");

  property p_bypass;
    sleep_state != PPO_DEEP && !input_en_override_en[0] |->
      alt_digital_in[0] == pad_in[0];
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("input disabled outside deep sleep");

  property p_wake_flag;
    wake_set != 8'h00 |=> (ext_int_flag & $past(wake_set)) == $past(wake_set);
  endproperty
  a_wake_flag: assert property (p_wake_flag)
    else $error("wake flag not set");

  property p_clk_read;
    ar_fire && clk7 && !clk_src.crystal |=> !s_axi_rdata[7];
  endproperty
  a_clk_read: assert property (p_clk_read)
    else $error("clock pin bit reads nonzero");

  property p_osc_off;
    async_timer_clk_sel && clk_src.intrc |=> !pad_oe[7];
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("bit 7 still driven as oscillator pin");

  property p_sync;
    ((die_sel == 8'hff) && $stable(pad_in)) [*3] |->
      pin_input_bit == pad_in;
  endproperty
  a_sync: assert property (p_sync)
    else $error("input register not settled");

  c_write: cover property (do_wr);
  c_read: cover property (ar_fire);
  c_wake: cover property (wake_set != 8'h00);
  c_spi: cover property (spi_m && pad_oe[5]);
endmodule

// ==== bench/ppo_board.sv ====
// board model: device drivers, board drivers, pull-ups, floating pins
module ppo_board (
  input  wire logic       clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last = 8'h00;
  // a floating pin shows the inverse of its last level, not a lucky 0
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pullup_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = ~last[i];
    end
  end
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i] | ext_en[i] | pullup_en[i]) last[i] <= pad_in[i];
    end
  end
endmodule

// ==== bench/tb.sv ====
// self-checking bench of the port pin block against a behavioural model
`include "ppo_cfg.svh"
module tb import ppo_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst_b = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  // response readies stay high: the bench takes every answer as it comes
  logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0]  wstrb = 0;
  logic [3:0]  ws = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rr;
  logic [7:0]  pad_in, pad_out, pad_oe, pullup_en, alt_in, ext_int_flag;
  logic [7:0]  ext_int_en = 0, ext_int_edge = 0, ext_en = 8'hff, ext_val = 0;
  ppo_sleep_t  sleep_state = PPO_ACTIVE;
  ppo_spi_t    spi = '0;
  ppo_tmr_t    tmr = '0;
  ppo_clksrc_t clk_src = 2'b01;
  logic [7:0]  dir_m, out_m, ck, oe, v, pu, ie, lvl, msk;
  logic [1:0]  ctrl_m;
  int          errors = 0, samples_checked = 0, cycles = 0;

  ppo_port dut (.clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en),
    .alt_digital_in(alt_in), .sleep_state(sleep_state),
    .ext_int_en(ext_int_en), .ext_int_edge(ext_int_edge),
    .ext_int_flag(ext_int_flag), .spi(spi), .tmr(tmr), .clk_src(clk_src));
  ppo_board board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));

  always #5 clk = ~clk;

  task finish_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, da, dw;
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= ws;
    awvalid <= 1; wvalid <= 1; da = 0; dw = 0;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = awready & !da;
      tw = wready & !dw;
      @(posedge clk);
      if (ta) begin awvalid <= 0; da = 1; end
      if (tw) begin wvalid <= 0; dw = 1; end
    end
    do @(negedge clk); while (!bvalid);
    chk(bresp, er, "bresp");
    @(posedge clk);
  endtask

  task rdr(input logic [7:0] a);
    araddr <= a; arvalid <= 1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 0;
    do @(negedge clk); while (!rvalid);
    rd = rdata;
    rr = rresp;
    @(posedge clk);
  endtask

  task model;
    logic [7:0] sm;
    sm = {8{spi.en & spi.master}} & 8'h3c;
    ck = {clk_src.crystal | (clk_src.intrc & ctrl_m[1]),
          ~clk_src.intrc | ctrl_m[1], 6'h00};
    oe = dir_m & ~ck & ~sm;
    v = out_m;
    if (tmr.t1a_en) v[1] = tmr.t1a_out;
    if (tmr.t1b_en) v[2] = tmr.t1b_out;
    if (sm[3] | tmr.t2_en) v[3] = spi.master_out | tmr.t2_out;
    if (sm[4]) v[4] = spi.slave_out;
    if (sm[5]) v[5] = spi.sck_out;
    pu = (~dir_m & out_m & ~{8{ctrl_m[0]}} & ~ck & ~sm)
       | (out_m & {8{ctrl_m[0]}} & sm);
    ie = ({8{sleep_state != PPO_DEEP}} | ext_int_en) & ~ck;
    lvl = (oe & v) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pu);
    msk = oe | ext_en | pu;
  endtask

  task check_pins;
    model();
    chk(pad_oe, oe, "oe");
    chk(pad_out, v & oe, "out");
    chk(pullup_en, pu, "pullup");
    chk(alt_in & msk, lvl & ie & msk, "alt");
  endtask

  task check_regs;
    rdr(`PPO_OFF_DIR);
    chk(rd, {24'h0, dir_m & ~ck}, "dir");
    rdr(`PPO_OFF_OUT);
    chk(rd, {24'h0, out_m & ~ck}, "outreg");
    rdr(`PPO_OFF_IN);
    chk(rd & {24'h0, msk}, {24'h0, lvl & ie & msk}, "in");
    rdr(`PPO_OFF_CTRL);
    chk(rd, {30'h0, ctrl_m}, "ctrl");
    chk(rr, `PPO_RESP_OK, "rresp");
  endtask

  task do_reset;
    @(negedge clk);
    #2 rst_b = 0;
    #1 chk(pad_oe, 8'h00, "rst oe");
    chk(pullup_en, 8'h00, "rst pullup");
    dir_m = 0; out_m = 0; ctrl_m = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    void'($urandom(32'hf9865a56));
    do_reset();
    for (int i = 0; i < 24; i++) begin
      spi <= ppo_spi_t'(5'($urandom));
      tmr <= ppo_tmr_t'(6'($urandom));
      clk_src <= ppo_clksrc_t'(2'($urandom));
      ext_en <= 8'($urandom);
      ext_val <= 8'($urandom);
      sleep_state <= i[0] ? PPO_IDLE : PPO_ACTIVE;
      dir_m = 8'($urandom);
      out_m = 8'($urandom);
      ctrl_m = 2'($urandom);
      wr(`PPO_OFF_DIR, dir_m, `PPO_RESP_OK);
      wr(`PPO_OFF_OUT, out_m, `PPO_RESP_OK);
      wr(`PPO_OFF_CTRL, {6'h0, ctrl_m}, `PPO_RESP_OK);
      repeat (3) @(posedge clk);
      #1 check_pins();
      check_regs();
    end
    // unmapped places answer with an error and zero data
    wr(8'h1c, 8'h55, `PPO_RESP_ERR);
    rdr(8'h14);
    chk(rd, 32'h0, "unmapped data");
    chk(rr, `PPO_RESP_ERR, "unmapped resp");
    // deep sleep with a pin configured for edge wake but not enabled
    spi <= '0; tmr <= '0; clk_src <= 2'b01; ext_en <= 8'hff;
    ext_val <= 8'h05; ext_int_edge <= 8'h0f; ext_int_en <= 8'h03;
    dir_m = 0; ctrl_m = 0;
    wr(`PPO_OFF_DIR, 8'h00, `PPO_RESP_OK);
    wr(`PPO_OFF_CTRL, 8'h00, `PPO_RESP_OK);
    sleep_state <= PPO_DEEP;
    repeat (4) @(posedge clk);
    #1 check_pins();
    @(posedge clk);
    sleep_state <= PPO_ACTIVE;
    repeat (3) @(posedge clk);
    #1 chk(ext_int_flag, 8'h04, "wake flag");
    check_pins();
    rdr(`PPO_OFF_FLAG);
    chk(rd, 32'h04, "flag read");
    wr(`PPO_OFF_FLAG, 8'h04, `PPO_RESP_OK);
    rdr(`PPO_OFF_FLAG);
    chk(rd, 32'h00, "flag clear");
    // byte lane 0 off: the write is answered but leaves the register alone
    ws = 4'h0;
    wr(`PPO_OFF_DIR, 8'hff, `PPO_RESP_OK);
    ws = 4'hf;
    rdr(`PPO_OFF_DIR);
    chk(rd, 32'h0, "strobe");
    // pull-ups on everywhere, then reset must drop them at once
    out_m = 8'hff;
    wr(`PPO_OFF_OUT, 8'hff, `PPO_RESP_OK);
    repeat (2) @(posedge clk);
    #1 check_pins();
    do_reset();
    #1 check_pins();
    finish_test();
  end
endmodule
